// *** hsc_pkg.sv ***
// Notes on behaviour
// - small package straps pick 90h, 94h, 96h
// - two-bit field picks general pin function
// - status shows sampled general pin level
// - test bit set stops monitoring converter
// - switch bit captures on-pin, host may overwrite
// - overcurrent retry default follows filter variant
// - undervoltage retry bit, resets to one
// - overvoltage retry bit, resets to one
// - alert enables per fault, output bit
// - live status read-only, top bit switch on
// - shorted switch flag: sense high while off
// - enable bit reads one while pin low
// - power bad reads one while feedback low
// - overcurrent flag during cool-down interval
// - undervoltage low and overvoltage high flags
// - low three command bits become pointer
// - alert pulled when latched fault enabled
// - alert response returns address, releases alert
// - no re-alert until fault (or its enable) cleared and recurs
package hsc_pkg;

    // ********************
    // register map and reset values
    // ********************
    localparam logic [2:0] REG_POWER_CONTROL = 3'h0;
    localparam logic [2:0] REG_ALERT_ENABLE  = 3'h1;
    localparam logic [2:0] REG_LIVE_COND     = 3'h2;
    localparam logic [7:0] RST_ALERT_ENABLE  = 8'h00;
    localparam logic [7:0] RD_UNMAPPED       = 8'h00;

    // ********************
    // control and alert enable register fields
    // ********************
    localparam int CTL_PIN_CFG_HI = 7;
    localparam int CTL_PIN_CFG_LO = 6;
    localparam int CTL_TEST       = 5;
    localparam int CTL_BCAST_EN   = 4;
    localparam int CTL_SWITCH_ON  = 3;
    localparam int CTL_RETRY_OC   = 2;
    localparam int CTL_RETRY_UV   = 1;
    localparam int CTL_RETRY_OV   = 0;
    localparam logic [7:0] RST_CONTROL_BASE = 8'h13;
    localparam int AL_GEN_OUT  = 6;
    localparam int AL_EN_HI    = 5;
    localparam int NUM_FAULTS  = 6;

    // ********************
    // slave addresses (8-bit form, R/W bit in bit 0; alert response address in 7-bit form)
    // ********************
    localparam logic [7:0] ADDR_STRAP_LOW  = 8'h90;
    localparam logic [7:0] ADDR_STRAP_OPEN = 8'h94;
    localparam logic [7:0] ADDR_STRAP_HIGH = 8'h96;
    localparam logic [7:0] ADDR_BROADCAST  = 8'hBE;
    localparam logic [6:0] ADDR_ALERT_RESP = 7'h0C;

    // ********************
    // types
    // ********************
    typedef enum logic [1:0] {
        STRAP_LOW  = 2'b00,
        STRAP_OPEN = 2'b01,
        STRAP_HIGH = 2'b10
    } hsc_strap_type;

    typedef enum logic [1:0] {
        PIN_NOT_POWER_BAD = 2'b00,
        PIN_POWER_BAD     = 2'b01,
        PIN_GEN_OUTPUT    = 2'b10,
        PIN_GEN_INPUT     = 2'b11
    } hsc_pin_cfg_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_CMD   = 3'b010,
        ST_DATA  = 3'b011,
        ST_READ  = 3'b100,
        ST_ARA   = 3'b101,
        ST_SKIP  = 3'b110
    } hsc_state_type;

    // byte-level events from the serial framing engine
    typedef struct packed {
        logic       start;
        logic       stop;
        logic       byte_valid;
        logic [7:0] rx_byte;
        logic       load;
    } hsc_frame_type;

    // live analog comparator and pin levels
    typedef struct packed {
        logic sense_over_1mv;
        logic enable_pin;
        logic output_feedback_input;
        logic oc_cooldown;
        logic undervolt_input;
        logic overvolt_input;
    } hsc_sense_type;

endpackage

// *** hsc_strap_decode.sv ***
module hsc_strap_decode
    import hsc_pkg::*;
(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rstn,
    // strap levels
    input  wire hsc_strap_type addr_strap_pin_zero,
    input  wire hsc_strap_type addr_strap_pin_one,
    input  wire hsc_strap_type addr_strap_pin_two,
    // decoded address
    output logic [7:0]         own_addr
);

    // ********************
    // address selection
    // ********************
    logic [7:0] own_addr_r;
    logic       caught_r;
    logic [7:0] decoded;

    // only the first strap moves the address in this package
    assign decoded = (addr_strap_pin_zero == STRAP_LOW)  ? ADDR_STRAP_LOW :
                     (addr_strap_pin_zero == STRAP_HIGH) ? ADDR_STRAP_HIGH :
                     ADDR_STRAP_OPEN;

    // straps caught once, on the first edge after reset release
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            own_addr_r <= ADDR_STRAP_OPEN;
            caught_r   <= 1'b0;
        end
        else if (!caught_r)
        begin
            own_addr_r <= decoded;
            caught_r   <= 1'b1;
        end
    end

    assign own_addr = own_addr_r;

endmodule // hsc_strap_decode

// *** hsc_alert_track.sv ***
module hsc_alert_track
    import hsc_pkg::*;
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rstn,
    // fault and enable bits
    input  wire logic [NUM_FAULTS-1:0] fault_latched,
    input  wire logic [NUM_FAULTS-1:0] alert_en,
    // release request and alert state
    input  wire logic                  release_req,
    output logic                       alert_active
);

    // ********************
    // per-fault new-event detection
    // ********************
    logic [NUM_FAULTS-1:0] seen_r;
    logic [NUM_FAULTS-1:0] new_evt;
    logic                  alert_r;

    genvar i;
    generate
        for (i = 0; i < NUM_FAULTS; i++)
        begin : g_fault
            // a fault counts again only after its latch or its alert enable was cleared
            assign new_evt[i] = fault_latched[i] & alert_en[i] & ~seen_r[i];
            always_ff @(posedge clock or negedge rstn)
            begin
                if (!rstn)
                    seen_r[i] <= 1'b0;
                else
                    seen_r[i] <= fault_latched[i] & alert_en[i];
            end
        end
    endgenerate

    // a new event beats a release in the same cycle
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            alert_r <= 1'b0;
        else if (|new_evt)
            alert_r <= 1'b1;
        else if (release_req)
            alert_r <= 1'b0;
    end

    assign alert_active = alert_r;

endmodule // hsc_alert_track

// *** hsc_regs.sv ***
module hsc_regs
    import hsc_pkg::*;
#(
    // 1 selects the long circuit-breaker filter variant
    parameter logic LONG_FILTER = 1'b0
)
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rstn,
    // framing engine side
    input  wire hsc_frame_type         frame,
    output logic                       ack,
    output logic [7:0]                 tx_byte,
    // address straps
    input  wire hsc_strap_type         addr_strap_pin_zero,
    input  wire hsc_strap_type         addr_strap_pin_one,
    input  wire hsc_strap_type         addr_strap_pin_two,
    // analog and pin levels
    input  wire hsc_sense_type         sense,
    input  wire logic                  on_pin_level,
    input  wire logic                  on_debounce_done,
    input  wire logic [NUM_FAULTS-1:0] fault_latched,
    // general pin, two-way
    input  wire logic                  gpio_in,
    output logic                       gpio_out,
    output logic                       gpio_oe_n,
    // alert pin, open drain
    output logic                       alert_out,
    output logic                       alert_oe_n,
    // power path controls
    output logic                       converter_run,
    output logic                       switch_on_cmd,
    output logic                       retry_oc,
    output logic                       retry_uv,
    output logic                       retry_ov
);

    // ********************
    // declarations
    // ********************
    hsc_state_type   state_r;
    hsc_state_type   state_nxt;
    logic [2:0]      ptr_r;
    logic [7:0]      ctrl_r;
    logic [7:0]      alert_en_r;
    logic [7:0]      status_r;
    logic [7:0]      status_nxt;
    logic [7:0]      tx_byte_r;
    logic [7:0]      rd_mux;
    logic [7:0]      own_addr;
    logic [7:0]      ctrl_reset;
    logic            alert_active;
    logic            release_req;
    logic            own_match;
    logic            bcast_match;
    logic            ara_match;
    logic            addr_ack;
    logic            wr_data;
    logic            wr_ctrl;
    logic            wr_alert;
    logic            ara_done;
    hsc_pin_cfg_type pin_cfg;

    // ********************
    // submodules
    // ********************
    hsc_strap_decode u_strap (
        .clock               (clock),
        .rstn                (rstn),
        .addr_strap_pin_zero (addr_strap_pin_zero),
        .addr_strap_pin_one  (addr_strap_pin_one),
        .addr_strap_pin_two  (addr_strap_pin_two),
        .own_addr            (own_addr)
    );

    hsc_alert_track u_alert (
        .clock         (clock),
        .rstn          (rstn),
        .fault_latched (fault_latched),
        .alert_en      (alert_en_r[AL_EN_HI:0]),
        .release_req   (release_req),
        .alert_active  (alert_active)
    );

    // ********************
    // address byte decode
    // ********************
    assign own_match   = (frame.rx_byte[7:1] == own_addr[7:1]);
    // broadcast takes writes only, and only while enabled
    assign bcast_match = (frame.rx_byte == ADDR_BROADCAST) & ctrl_r[CTL_BCAST_EN];
    // answer the alert response read only while holding alert
    assign ara_match   = (frame.rx_byte[7:1] == ADDR_ALERT_RESP)
                       & frame.rx_byte[0] & alert_active;
    assign addr_ack    = own_match | bcast_match | ara_match;

    // ack is combinational, valid in the byte_valid cycle
    assign ack = frame.byte_valid & (((state_r == ST_ADDR) & addr_ack)
               | (state_r == ST_CMD) | (state_r == ST_DATA) | (state_r == ST_SKIP));

    // being addressed, or finishing the response, frees alert
    assign ara_done    = frame.stop & (state_r == ST_ARA);
    assign release_req = (frame.byte_valid & (state_r == ST_ADDR) & own_match)
                       | ara_done;

    // ********************
    // transaction sequencer
    // ********************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE, ST_SKIP, ST_CMD, ST_DATA, ST_READ, ST_ARA:
            begin
                if (state_r == ST_CMD && frame.byte_valid)
                    state_nxt = ST_DATA;
                else if (state_r == ST_DATA && frame.byte_valid)
                    state_nxt = ST_SKIP;  // later data bytes acked, ignored
            end
            ST_ADDR:
            begin
                if (frame.byte_valid)
                begin
                    if (ara_match)
                        state_nxt = ST_ARA;
                    else if (own_match && frame.rx_byte[0])
                        state_nxt = ST_READ;
                    else if ((own_match || bcast_match) && !frame.rx_byte[0])
                        state_nxt = ST_CMD;
                    else
                        state_nxt = ST_IDLE;
                end
            end
            default:
                state_nxt = ST_IDLE;
        endcase
        // start and stop override everything else
        if (frame.start)
            state_nxt = ST_ADDR;
        else if (frame.stop)
            state_nxt = ST_IDLE;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // pointer keeps only the low three command bits
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            ptr_r <= REG_POWER_CONTROL;
        else if (frame.byte_valid && state_r == ST_CMD)
            ptr_r <= frame.rx_byte[2:0];
    end

    // ********************
    // register writes
    // ********************
    assign wr_data  = frame.byte_valid & (state_r == ST_DATA);
    assign wr_ctrl  = wr_data & (ptr_r == REG_POWER_CONTROL);
    assign wr_alert = wr_data & (ptr_r == REG_ALERT_ENABLE);
    // the status offset has no write path at all

    // overcurrent retry default tracks the filter variant
    assign ctrl_reset = RST_CONTROL_BASE | ({7'h00, LONG_FILTER} << CTL_RETRY_OC);

    // debounce capture wins the switch bit over a host write in the same cycle; the write's other bits still land
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            ctrl_r <= RST_CONTROL_BASE;
        else if (on_debounce_done)
            ctrl_r <= (wr_ctrl ? frame.rx_byte : ctrl_r) & ~(8'h01 << CTL_SWITCH_ON)
                    | ({7'h00, on_pin_level} << CTL_SWITCH_ON);
        else if (wr_ctrl)
            ctrl_r <= frame.rx_byte;
    end

    // the variant default is applied once after reset release
    logic ctrl_init_r;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            ctrl_init_r <= 1'b0;
        else
            ctrl_init_r <= 1'b1;
    end

    logic oc_retry_r;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            oc_retry_r <= 1'b0;
        else if (!ctrl_init_r)
            oc_retry_r <= ctrl_reset[CTL_RETRY_OC];
        else if (wr_ctrl)
            oc_retry_r <= frame.rx_byte[CTL_RETRY_OC];
    end

    // top bit is unused and always reads zero
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            alert_en_r <= RST_ALERT_ENABLE;
        else if (wr_alert)
            alert_en_r <= {1'b0, frame.rx_byte[AL_GEN_OUT:0]};
    end

    // ********************
    // live status, resampled every cycle
    // ********************
    assign status_nxt = {
        ctrl_r[CTL_SWITCH_ON],
        gpio_in,
        sense.sense_over_1mv & ~ctrl_r[CTL_SWITCH_ON],
        ~sense.enable_pin,
        ~sense.output_feedback_input,
        sense.oc_cooldown,
        ~sense.undervolt_input,
        sense.overvolt_input
    };

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            status_r <= 8'h00;
        else
            status_r <= status_nxt;
    end

    // ********************
    // read path
    // ********************
    // unmapped pointers read zero; fault and converter data live elsewhere
    assign rd_mux = (ptr_r == REG_POWER_CONTROL) ?
                        {ctrl_r[7:3], oc_retry_r, ctrl_r[1:0]} :
                    (ptr_r == REG_ALERT_ENABLE) ? alert_en_r :
                    (ptr_r == REG_LIVE_COND)    ? status_r : RD_UNMAPPED;

    // a word read repeats the same register since ptr holds
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            tx_byte_r <= 8'h00;
        else if (frame.load && state_r == ST_ARA)
            tx_byte_r <= {own_addr[7:1], 1'b0};
        else if (frame.load && state_r == ST_READ)
            tx_byte_r <= rd_mux;
    end

    assign tx_byte = tx_byte_r;

    // ********************
    // general pin and power path outputs
    // ********************
    assign pin_cfg   = hsc_pin_cfg_type'({ctrl_r[CTL_PIN_CFG_LO], ctrl_r[CTL_PIN_CFG_HI]});
    // in the two power-bad modes the pin follows the live power-bad bit, so it lags the inputs a cycle
    assign gpio_out  = (pin_cfg == PIN_NOT_POWER_BAD) ? ~status_r[3] :
                       (pin_cfg == PIN_POWER_BAD)     ?  status_r[3] :
                       alert_en_r[AL_GEN_OUT];
    assign gpio_oe_n = (pin_cfg == PIN_GEN_INPUT);

    // alert pulls low while held
    assign alert_out  = 1'b0;
    assign alert_oe_n = ~alert_active;

    assign converter_run = ~ctrl_r[CTL_TEST];
    assign switch_on_cmd = ctrl_r[CTL_SWITCH_ON];
    assign retry_oc      = oc_retry_r;
    assign retry_uv      = ctrl_r[CTL_RETRY_UV];
    assign retry_ov      = ctrl_r[CTL_RETRY_OV];

endmodule // hsc_regs

// *** hsc_regs_asserts.sv ***
module hsc_regs_asserts
    import hsc_pkg::*;
#(
    parameter logic LONG_FILTER = 1'b0
)
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rstn,
    // framing side
    input  wire hsc_frame_type         frame,
    input  wire logic                  ack,
    input  wire logic [7:0]            tx_byte,
    // pin levels
    input  wire logic                  on_pin_level,
    input  wire logic                  on_debounce_done,
    input  wire logic [NUM_FAULTS-1:0] fault_latched,
    // outputs watched
    input  wire logic                  alert_out,
    input  wire logic                  alert_oe_n,
    input  wire logic                  converter_run,
    input  wire logic                  switch_on_cmd,
    input  wire logic                  retry_oc,
    input  wire logic                  retry_uv,
    input  wire logic                  retry_ov
);
    // one domain, so clock and disable are given once
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // ****************************************
    // checks
    // ****************************************
    chk_alert_data_low: assert property (alert_out == 1'b0)
        else $error("alert data not low");
    chk_alert_has_cause: assert property ($fell(alert_oe_n) |-> $past(fault_latched) != '0)
        else $error("alert pulled with no fault");
    chk_ack_in_byte: assert property (ack |-> frame.byte_valid)
        else $error("ack outside a byte");
    chk_oc_retry_default: assert property ($rose(rstn) |=> retry_oc == LONG_FILTER)
        else $error("overcurrent retry default wrong");
    chk_reset_outputs: assert property ($rose(rstn) |-> converter_run && retry_uv && retry_ov
        && !switch_on_cmd && alert_oe_n)
        else $error("outputs wrong at reset release");
    chk_debounce_capture: assert property (on_debounce_done |=>
        switch_on_cmd == $past(on_pin_level))
        else $error("switch bit missed on-pin level");
    chk_tx_holds: assert property (!frame.load |=> $stable(tx_byte))
        else $error("transmit byte moved without load");
    chk_ctl_by_write: assert property ($changed({converter_run, retry_uv, retry_ov}) |->
        $past(frame.byte_valid))
        else $error("control output moved without write");
    chk_switch_cause: assert property ($changed(switch_on_cmd) |->
        $past(frame.byte_valid || on_debounce_done))
        else $error("switch command moved without cause");
endmodule // hsc_regs_asserts

bind hsc_regs hsc_regs_asserts #(.LONG_FILTER(LONG_FILTER)) chk_u (
    .clock(clock), .rstn(rstn), .frame(frame), .ack(ack), .tx_byte(tx_byte),
    .on_pin_level(on_pin_level), .on_debounce_done(on_debounce_done),
    .fault_latched(fault_latched), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .converter_run(converter_run), .switch_on_cmd(switch_on_cmd),
    .retry_oc(retry_oc), .retry_uv(retry_uv), .retry_ov(retry_ov)
);

// *** hsc_host_model.sv ***
module hsc_host_model
    import hsc_pkg::*;
(
    // clock and answers
    input  wire logic       clock,
    input  wire logic       ack,
    input  wire logic [7:0] tx_byte,
    // events toward the block
    output hsc_frame_type   frame
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // event kinds: start, stop, byte, load
    // ****************************************
    localparam logic [3:0] EV_S = 4'h8;
    localparam logic [3:0] EV_P = 4'h4;
    localparam logic [3:0] EV_V = 4'h2;
    localparam logic [3:0] EV_L = 4'h1;
    logic [7:0] last_b = 8'hA5;

    initial frame = '0;

    // one event a cycle; a stale byte is flipped so it never looks valid
    task automatic ev(input logic [3:0] k, input logic [7:0] b, output logic a);
        @(negedge clock);
        last_b = (k == EV_V) ? b : ~last_b;
        frame = {k[3], k[2], k[1], last_b, k[0]};
        #5 a = ack;
    endtask

    // byte write; a holds address, command and data acks
    task automatic wr(input logic [7:0] adr, input logic [2:0] ptr, input logic [7:0] dat,
                      output logic [2:0] a);
        logic x;
        ev(EV_S, 8'h00, x);
        ev(EV_V, adr & 8'hFE, a[2]);
        ev(EV_V, {5'h00, ptr}, a[1]);
        ev(EV_V, dat, a[0]);
        ev(EV_P, 8'h00, x);
        ev(4'h0, 8'h00, x);
    endtask

    // byte read with repeated start
    task automatic rd(input logic [7:0] adr, input logic [2:0] ptr, output logic [7:0] dat,
                      output logic [2:0] a);
        logic x;
        ev(EV_S, 8'h00, x);
        ev(EV_V, adr & 8'hFE, a[2]);
        ev(EV_V, {5'h00, ptr}, a[1]);
        ev(EV_S, 8'h00, x);
        ev(EV_V, adr | 8'h01, a[0]);
        ev(EV_L, 8'h00, x);
        ev(4'h0, 8'h00, x);
        dat = tx_byte;
        ev(EV_P, 8'h00, x);
        ev(4'h0, 8'h00, x);
    endtask

    // alert response read
    task automatic ara(output logic [7:0] dat, output logic a);
        logic x;
        ev(EV_S, 8'h00, x);
        ev(EV_V, {ADDR_ALERT_RESP, 1'b1}, a);
        ev(EV_L, 8'h00, x);
        ev(4'h0, 8'h00, x);
        dat = tx_byte;
        ev(EV_P, 8'h00, x);
        ev(4'h0, 8'h00, x);
    endtask
endmodule // hsc_host_model

// *** tb.sv ***
module tb
    import hsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clock = 1'b0;
    logic                  rstn = 1'b0;
    hsc_frame_type         frame;
    logic                  ack;
    logic [7:0]            tx_byte;
    hsc_strap_type         strap0 = STRAP_OPEN;
    hsc_sense_type         sense = 6'h08;
    logic                  on_pin_level = 1'b0;
    logic                  on_debounce_done = 1'b0;
    logic [NUM_FAULTS-1:0] fault_latched = '0;
    logic                  gpio_ext = 1'b0;
    logic                  gpio_out, gpio_oe_n, alert_out, alert_oe_n;
    logic                  converter_run, switch_on_cmd, retry_oc, retry_uv, retry_ov;
    logic [7:0]            own = 8'h94;
    logic [7:0]            d;
    logic [2:0]            a;
    logic                  x;
    int                    fails = 0;
    int                    n_compared = 0;

    // pin level: the block wins while it drives, else the board side
    wire logic gpio_in = gpio_oe_n ? gpio_ext : gpio_out;

    always #10 clock = ~clock;

    hsc_regs dut_u (
        .clock(clock), .rstn(rstn), .frame(frame), .ack(ack), .tx_byte(tx_byte),
        .addr_strap_pin_zero(strap0), .addr_strap_pin_one(STRAP_OPEN),
        .addr_strap_pin_two(STRAP_OPEN), .sense(sense), .on_pin_level(on_pin_level),
        .on_debounce_done(on_debounce_done), .fault_latched(fault_latched),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .alert_out(alert_out), .alert_oe_n(alert_oe_n), .converter_run(converter_run),
        .switch_on_cmd(switch_on_cmd), .retry_oc(retry_oc), .retry_uv(retry_uv),
        .retry_ov(retry_ov)
    );

    hsc_host_model host_u (.clock(clock), .ack(ack), .tx_byte(tx_byte), .frame(frame));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic do_reset();
        @(negedge clock);
        rstn = 1'b0;
        repeat (6) @(negedge clock);
        rstn = 1'b1;
        repeat (2) @(negedge clock);
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_defaults();
        chk({converter_run, switch_on_cmd, retry_oc, retry_uv, retry_ov}, 8'h13);
        chk({gpio_oe_n, gpio_out, alert_oe_n}, 8'h03);
        host_u.rd(own, REG_POWER_CONTROL, d, a);
        chk(d, 8'h13);
        host_u.rd(own, REG_ALERT_ENABLE, d, a);
        chk(d, 8'h00);
        host_u.rd(own, 3'h5, d, a);
        chk({a, d[4:0]}, 8'hE0);
        $display("test defaults done");
    endtask

    // each strap level needs a fresh reset, straps are taken once
    task automatic t_straps();
        hsc_strap_type s [3] = '{STRAP_LOW, STRAP_OPEN, STRAP_HIGH};
        logic [7:0]    e [3] = '{8'h90, 8'h94, 8'h96};
        for (int i = 0; i < 3; i++)
        begin
            strap0 = s[i];
            do_reset();
            host_u.wr(e[i], REG_ALERT_ENABLE, 8'h00, a);
            chk(a, 8'h07);
            host_u.wr(e[i] ^ 8'h06, REG_ALERT_ENABLE, 8'h00, a);
            chk(a, 8'h00);
        end
        strap0 = STRAP_OPEN;
        do_reset();
        $display("test straps done");
    endtask

    task automatic t_control();
        host_u.wr(own, REG_POWER_CONTROL, 8'h2F, a);
        chk({converter_run, switch_on_cmd, retry_oc, retry_uv, retry_ov}, 8'h0F);
        host_u.wr(own, REG_POWER_CONTROL, 8'h06, a);
        chk({converter_run, switch_on_cmd, retry_oc, retry_uv, retry_ov}, 8'h16);
        host_u.wr(ADDR_BROADCAST, REG_POWER_CONTROL, 8'h13, a);
        chk(a, 8'h00);
        host_u.rd(own, REG_POWER_CONTROL, d, a);
        chk(d, 8'h06);
        host_u.wr(own, REG_POWER_CONTROL, 8'h17, a);
        host_u.wr(ADDR_BROADCAST, REG_POWER_CONTROL, 8'h13, a);
        host_u.rd(own, REG_POWER_CONTROL, d, a);
        chk({a, d[4:0]}, 8'hF3);
        $display("test control done");
    endtask

    // feedback high so the power bad bit is 0, output bit set
    task automatic t_gpio();
        logic [7:0] ex [4] = '{8'h01, 8'h01, 8'h00, 8'h02};
        host_u.wr(own, REG_ALERT_ENABLE, 8'h40, a);
        for (int m = 0; m < 4; m++)
        begin
            host_u.wr(own, REG_POWER_CONTROL, {m[1:0], 6'h13}, a);
            chk({gpio_oe_n, gpio_oe_n ? 1'b0 : gpio_out}, ex[m]);
        end
        for (int v = 0; v < 2; v++)
        begin
            gpio_ext = v[0];
            host_u.rd(own, REG_LIVE_COND, d, a);
            chk(d[6], v[0]);
        end
        host_u.wr(own, REG_POWER_CONTROL, 8'h53, a);
        host_u.wr(own, REG_ALERT_ENABLE, 8'h00, a);
        chk(gpio_out, 1'b0);
        host_u.wr(own, REG_POWER_CONTROL, 8'h13, a);
        $display("test gpio done");
    endtask

    task automatic t_status();
        sense = 6'b101010;
        host_u.rd(own, REG_LIVE_COND, d, a);
        chk(d, 8'h70);
        sense = 6'b110101;
        host_u.wr(own, REG_POWER_CONTROL, 8'h1B, a);
        host_u.rd(own, REG_LIVE_COND, d, a);
        chk(d, 8'h8F);
        host_u.wr(own, REG_LIVE_COND, 8'hFF, a);
        host_u.rd(own, REG_LIVE_COND, d, a);
        chk({a, d[4:0]}, 8'hEF);
        sense = 6'h08;
        host_u.wr(own, REG_POWER_CONTROL, 8'h13, a);
        $display("test status done");
    endtask

    task automatic t_alert();
        host_u.wr(own, REG_ALERT_ENABLE, 8'h01, a);
        fault_latched = 6'h01;
        repeat (3) @(negedge clock);
        chk(alert_oe_n, 1'b0);
        host_u.ara(d, x);
        chk(d, own);
        chk({x, alert_oe_n}, 8'h03);
        repeat (4) @(negedge clock);
        chk(alert_oe_n, 1'b1);
        fault_latched = 6'h00;
        repeat (2) @(negedge clock);
        fault_latched = 6'h01;
        repeat (3) @(negedge clock);
        chk(alert_oe_n, 1'b0);
        host_u.rd(own, REG_POWER_CONTROL, d, a);
        chk(alert_oe_n, 1'b1);
        fault_latched = 6'h00;
        host_u.wr(own, REG_ALERT_ENABLE, 8'h00, a);
        fault_latched = 6'h02;
        repeat (3) @(negedge clock);
        host_u.ara(d, x);
        chk({x, alert_oe_n}, 8'h01);
        fault_latched = 6'h00;
        $display("test alert done");
    endtask

    task automatic t_debounce();
        for (int v = 1; v >= 0; v--)
        begin
            @(negedge clock);
            on_pin_level = v[0];
            on_debounce_done = 1'b1;
            @(negedge clock);
            on_debounce_done = 1'b0;
            chk(switch_on_cmd, v[0]);
        end
        $display("test debounce done");
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial
    begin
        do_reset();
        t_defaults();
        t_straps();
        t_control();
        t_gpio();
        t_status();
        t_alert();
        t_debounce();
        results();
    end

    // whole run is a few hundred cycles; this leaves ample margin
    initial
    begin
        #400000;
        fails++;
        $display("watchdog expired");
        results();
    end
endmodule // tb
